// file: inc/fpes_pkg.sv
// Purpose: Shared constants and types for the float exception status unit
// Assumes: One core clock, asynchronous active-high reset
// Notes:   Status word layout, trap type codes and exception bit order
package fpes_pkg;

   // -------------------------------------------------------------
   // Status word layout
   // -------------------------------------------------------------
   localparam int STATUS_W      = 32;
   localparam int CUR_LSB       = 0;
   localparam int CUR_MSB       = 4;
   localparam int ACC_LSB       = 5;
   localparam int ACC_MSB       = 9;
   localparam int QNE_BIT       = 13;
   localparam int TTYPE_LSB     = 14;
   localparam int TTYPE_MSB     = 16;
   localparam int MASK_LSB      = 23;
   localparam int MASK_MSB      = 27;
   localparam int EXC_W         = 5;
   localparam int TTYPE_W       = 3;

   // Exception bit positions inside a five-bit field
   localparam int EX_NV         = 4;
   localparam int EX_OF         = 3;
   localparam int EX_UF         = 2;
   localparam int EX_DZ         = 1;
   localparam int EX_NX         = 0;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [4:0] MASK_RST  = 5'h00;
   localparam logic [4:0] ACC_RST   = 5'h00;
   localparam logic [4:0] CUR_RST   = 5'h00;

   // -------------------------------------------------------------
   // Trap type codes
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      FPES_TT_NONE    = 3'h0,
      FPES_TT_IEEE    = 3'h1,
      FPES_TT_INCOMP  = 3'h2,
      FPES_TT_UNSUPP  = 3'h3,
      FPES_TT_RSVD4   = 3'h4,
      FPES_TT_RSVD5   = 3'h5,
      FPES_TT_MISALGN = 3'h6,
      FPES_TT_RSVD7   = 3'h7
   } fpes_ttype_t;

   // Raw conditions reported by the datapath for one operation
   typedef struct packed {
      logic invalid_op;
      logic result_inf_from_finite;
      logic ovf_rounded;
      logic tiny_before_round;
      logic result_zero_unrounded;
      logic inexact;
   } fpes_raw_t;

endpackage

// file: inc/fpes_exc_if.sv
// Purpose: Carries one operation's outcome from classifier to status logic
// Assumes: Used only between the unit's own modules
// Notes:   Valid for the cycle in which an operation completes
`timescale 1ns/1ps
interface fpes_exc_if;
   import fpes_pkg::*;
   logic              op_done;
   logic [4:0]        cur_new;
   logic              ieee_trap;
   fpes_ttype_t       ttype;

   modport src (output op_done, output cur_new, output ieee_trap,
                output ttype);
   modport dst (input op_done, input cur_new, input ieee_trap,
                input ttype);
endinterface

// file: hdl/fpes_detect.sv
// Purpose: Turns raw datapath conditions into IEEE exception flags
// Assumes: Tininess is judged before rounding by the datapath
// Notes:   Pure combinational
`timescale 1ns/1ps
module fpes_detect
   import fpes_pkg::*;
(
   input  wire fpes_raw_t  i_raw,
   input  wire logic       i_uf_mask,
   output logic [4:0]      o_flags
);
   logic tiny_nonzero;

   assign tiny_nonzero = i_raw.tiny_before_round &
                         ~i_raw.result_zero_unrounded;   // RULE18

   always_comb begin
      o_flags        = 5'h00;
      o_flags[EX_NV] = i_raw.invalid_op;                // RULE15
      o_flags[EX_OF] = i_raw.ovf_rounded;               // RULE16
      // Masked underflow needs loss of accuracy; trapped does not
      o_flags[EX_UF] = i_uf_mask ? tiny_nonzero
                                 : tiny_nonzero & i_raw.inexact; // RULE17
      o_flags[EX_DZ] = i_raw.result_inf_from_finite;    // RULE19
      o_flags[EX_NX] = i_raw.inexact;                   // RULE20
   end
endmodule

// file: hdl/fpes_classify.sv
// Purpose: Picks new current bits, IEEE trap and trap type per operation
// Assumes: Flags come from fpes_detect
// Notes:   Priority encodes the trap type
`timescale 1ns/1ps
module fpes_classify
   import fpes_pkg::*;
(
   input  wire logic       i_op_done,
   input  wire logic [4:0] i_flags,
   input  wire logic [4:0] i_mask,
   input  wire logic       i_unsupported,
   input  wire logic       i_quad,
   input  wire logic [4:0] i_reg_a,
   input  wire logic [4:0] i_reg_b,
   input  wire logic [4:0] i_reg_d,
   input  wire logic       i_incomplete,
   fpes_exc_if.src         exc
);
   logic       misalign;
   logic [4:0] cur;
   logic       trap;

   assign misalign = i_quad & ((|i_reg_a[1:0]) | (|i_reg_b[1:0]) |
                               (|i_reg_d[1:0]));                  // RULE2

   always_comb begin
      cur  = i_flags;
      trap = |(i_flags & i_mask);                                 // RULE6
      // One bit only on a trap: overflow, underflow, then the rest
      if (trap) begin                                             // RULE9
         cur = 5'h00;
         if (i_flags[EX_OF] & i_mask[EX_OF])
            cur[EX_OF] = 1'b1;                                    // RULE10
         else if (i_flags[EX_UF] & i_mask[EX_UF])
            cur[EX_UF] = 1'b1;                                    // RULE11
         else if (i_flags[EX_NV] & i_mask[EX_NV])
            cur[EX_NV] = 1'b1;                                    // RULE23
         else if (i_flags[EX_DZ] & i_mask[EX_DZ])
            cur[EX_DZ] = 1'b1;                                    // RULE23
         else
            cur[EX_NX] = 1'b1;                                    // RULE10
      end
   end

   assign exc.op_done = i_op_done;
   assign exc.cur_new = cur;
   // Trap type priority; code 5 is never produced
   always_comb begin
      exc.ieee_trap = 1'b0;
      if (i_unsupported)
         exc.ttype = FPES_TT_UNSUPP;                              // RULE3
      else if (misalign)
         exc.ttype = FPES_TT_MISALGN;                             // RULE2
      else if (i_incomplete)
         exc.ttype = FPES_TT_INCOMP;                              // RULE21
      else if (trap) begin
         exc.ttype     = FPES_TT_IEEE;
         exc.ieee_trap = 1'b1;
      end else
         exc.ttype = FPES_TT_NONE;                                // RULE1
   end
endmodule

// file: hdl/fpes_top.sv
// Purpose: Float exception status: current, accrued, mask and trap type
// Assumes: Datapath reports one completed operation per i_op_done pulse
// Notes:   Status reached by load/store status instructions on plain ports
//
// Behaviour
// RULE1 - Trap type 5 is never written
// RULE2 - Misaligned quad register gives misc trap, type 6
// RULE3 - Unsupported quad op reports 3, not 6
// RULE4 - Queue-not-empty bit reads zero, writes dropped
// RULE5 - Accrued bits gather only masked exceptions
// RULE6 - Mask AND current decides trap or accrue
// RULE7 - Status loads write accrued field freely
// RULE8 - Current bits reflect only latest operation
// RULE9 - Current updates only untrapped or IEEE-trapped ops
// RULE10 - Overflow response follows overflow/inexact mask bits
// RULE11 - Underflow response follows underflow/inexact mask bits
// RULE12 - Other traps leave current bits unchanged
// RULE13 - Mask at bits 27:23, readable and writable
// RULE14 - Field bit order invalid to inexact
// RULE15 - Invalid flagged for improper operands
// RULE16 - Overflow flagged past largest finite value
// RULE17 - Underflow rules depend on underflow mask
// RULE18 - Tininess judged before rounding
// RULE19 - Divide-by-zero flags exact infinite from finite
// RULE20 - Inexact flags rounded differing from exact
// RULE21 - Trap type holds highest priority cause
// RULE22 - Trap type cleared by store or nontrapping op
// RULE23 - Invalid/divide-by-zero trap when enabled
`timescale 1ns/1ps
module fpes_top
   import fpes_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_op_done,
   input  wire fpes_raw_t   i_raw,
   input  wire logic        i_unsupported,
   input  wire logic        i_quad,
   input  wire logic [4:0]  i_reg_a,
   input  wire logic [4:0]  i_reg_b,
   input  wire logic [4:0]  i_reg_d,
   input  wire logic        i_incomplete,
   input  wire logic        i_load_status,
   input  wire logic        i_load_status_wide,
   input  wire logic [31:0] i_load_data,
   input  wire logic        i_store_done,
   output logic [31:0]      o_fp_status_reg,
   output logic             o_float_ieee_trap,
   output logic             o_float_misc_trap
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [4:0]  trap_enable_mask_field_q;
   logic [4:0]  accrued_exception_field_q;
   logic [4:0]  current_exception_field_q;
   fpes_ttype_t ttype_q;
   logic        ieee_trap_q;
   logic        misc_trap_q;
   logic [4:0]  flags;
   logic        load_any;
   logic        misc;

   fpes_exc_if exc ();

   assign load_any = i_load_status | i_load_status_wide;

   // ----------------------------------------------------------------
   // Detection and classification
   // ----------------------------------------------------------------
   fpes_detect u_detect (
      .i_raw     (i_raw),
      .i_uf_mask (trap_enable_mask_field_q[EX_UF]),
      .o_flags   (flags)
   );

   fpes_classify u_classify (
      .i_op_done     (i_op_done),
      .i_flags       (flags),
      .i_mask        (trap_enable_mask_field_q),
      .i_unsupported (i_unsupported),
      .i_quad        (i_quad),
      .i_reg_a       (i_reg_a),
      .i_reg_b       (i_reg_b),
      .i_reg_d       (i_reg_d),
      .i_incomplete  (i_incomplete),
      .exc           (exc)
   );

   assign misc = (exc.ttype != FPES_TT_NONE) &&
                 (exc.ttype != FPES_TT_IEEE);

   // ----------------------------------------------------------------
   // Trap enable mask
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         trap_enable_mask_field_q <= MASK_RST;
      else if (load_any)
         trap_enable_mask_field_q <= i_load_data[MASK_MSB:MASK_LSB]; // RULE13
   end

   // ----------------------------------------------------------------
   // Accrued exceptions
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         accrued_exception_field_q <= ACC_RST;
      else if (load_any)
         accrued_exception_field_q <= i_load_data[ACC_MSB:ACC_LSB]; // RULE7
      else if (exc.op_done && exc.ttype == FPES_TT_NONE)
         accrued_exception_field_q <= accrued_exception_field_q |
                                      exc.cur_new;                  // RULE5
   end

   // ----------------------------------------------------------------
   // Current exceptions
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         current_exception_field_q <= CUR_RST;
      else if (exc.op_done && !misc)                                // RULE12
         current_exception_field_q <= exc.cur_new;                  // RULE8
      else if (load_any)
         current_exception_field_q <= i_load_data[CUR_MSB:CUR_LSB];
   end

   // ----------------------------------------------------------------
   // Trap type; loads leave it alone
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         ttype_q <= FPES_TT_NONE;
      else if (exc.op_done)
         ttype_q <= exc.ttype;                                      // RULE21
      else if (i_store_done)
         ttype_q <= FPES_TT_NONE;                                   // RULE22
   end

   // ----------------------------------------------------------------
   // Trap requests, one-cycle pulses
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ieee_trap_q <= 1'b0;
         misc_trap_q <= 1'b0;
      end else begin
         ieee_trap_q <= exc.op_done & exc.ieee_trap;                // RULE6
         misc_trap_q <= exc.op_done & misc;                         // RULE2
      end
   end

   assign o_float_ieee_trap = ieee_trap_q;
   assign o_float_misc_trap = misc_trap_q;

   // ----------------------------------------------------------------
   // Status word read view
   // ----------------------------------------------------------------
   always_comb begin
      o_fp_status_reg                    = 32'h0000_0000;
      o_fp_status_reg[MASK_MSB:MASK_LSB] = trap_enable_mask_field_q;
      o_fp_status_reg[TTYPE_MSB:TTYPE_LSB] = ttype_q;
      o_fp_status_reg[QNE_BIT]           = 1'b0;                    // RULE4
      o_fp_status_reg[ACC_MSB:ACC_LSB]   = accrued_exception_field_q; // RULE14
      o_fp_status_reg[CUR_MSB:CUR_LSB]   = current_exception_field_q;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_ttype_no_five: assert property ( // RULE1
      @(posedge i_clk) disable iff (i_rst)
      ttype_q != FPES_TT_RSVD5)
      else $error("reserved trap type stored");

   a_misalign_trap: assert property ( // RULE2
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && !i_unsupported && i_quad && |i_reg_a[1:0])
      |=> (o_float_misc_trap && ttype_q == FPES_TT_MISALGN))
      else $error("misaligned quad not trapped");

   a_unsupp_first: assert property ( // RULE3
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && i_unsupported) |=> ttype_q == FPES_TT_UNSUPP)
      else $error("unsupported op not type 3");

   a_qne_zero: assert property ( // RULE4
      @(posedge i_clk) disable iff (i_rst)
      o_fp_status_reg[QNE_BIT] == 1'b0)
      else $error("queue bit not zero");

   a_acc_hold_trap: assert property ( // RULE6
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && !load_any && exc.ttype != FPES_TT_NONE)
      |=> $stable(accrued_exception_field_q))
      else $error("accrued changed on trap");

   a_acc_gather: assert property ( // RULE5
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && !load_any && exc.ttype == FPES_TT_NONE)
      |=> accrued_exception_field_q ==
          ($past(accrued_exception_field_q) | $past(exc.cur_new)))
      else $error("accrued not gathered");

   a_load_acc: assert property ( // RULE7
      @(posedge i_clk) disable iff (i_rst)
      load_any |=> accrued_exception_field_q ==
                   $past(i_load_data[ACC_MSB:ACC_LSB]))
      else $error("load did not set accrued");

   a_cur_keep: assert property ( // RULE12
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && misc && !load_any)
      |=> $stable(current_exception_field_q))
      else $error("current changed on misc trap");

   a_ieee_onehot: assert property ( // RULE9
      @(posedge i_clk) disable iff (i_rst)
      o_float_ieee_trap |-> $onehot(current_exception_field_q))
      else $error("trap current not one-hot");

   a_ttype_clear: assert property ( // RULE22
      @(posedge i_clk) disable iff (i_rst)
      (i_store_done && !i_op_done) |=> ttype_q == FPES_TT_NONE)
      else $error("store did not clear type");

   // ----------------------------------------------------------------
   // Checks on mask, trap type, trap requests and exception bits
   // ----------------------------------------------------------------
   a_mask_load: assert property ( // RULE13
      @(posedge i_clk) disable iff (i_rst)
      load_any |=> trap_enable_mask_field_q ==
                   $past(i_load_data[MASK_MSB:MASK_LSB]))
      else $error("load did not set mask");

   a_mask_hold: assert property ( // RULE13
      @(posedge i_clk) disable iff (i_rst)
      !load_any
      |=> $stable(trap_enable_mask_field_q))
      else $error("mask changed without load");

   a_ttype_load_keep: assert property ( // RULE22
      @(posedge i_clk) disable iff (i_rst)
      (load_any && !i_op_done && !i_store_done)
      |=> $stable(ttype_q))
      else $error("load changed trap type");

   a_cur_latest: assert property ( // RULE8
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && exc.ttype == FPES_TT_NONE)
      |=> current_exception_field_q == $past(flags))
      else $error("current not latest flags");

   a_ieee_type: assert property ( // RULE6
      @(posedge i_clk) disable iff (i_rst)
      o_float_ieee_trap
      |-> ttype_q == FPES_TT_IEEE)
      else $error("ieee trap without type 1");

   a_misc_type: assert property ( // RULE21
      @(posedge i_clk) disable iff (i_rst)
      o_float_misc_trap |-> (ttype_q == FPES_TT_UNSUPP ||
         ttype_q == FPES_TT_MISALGN || ttype_q == FPES_TT_INCOMP))
      else $error("misc trap with wrong type");

   a_incomp_type: assert property ( // RULE21
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && i_incomplete && !i_unsupported && !i_quad)
      |=> ttype_q == FPES_TT_INCOMP)
      else $error("incomplete op not type 2");

   a_of_trap_bit: assert property ( // RULE10
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && exc.ieee_trap && flags[EX_OF] &&
       trap_enable_mask_field_q[EX_OF])
      |=> current_exception_field_q == 5'h08)
      else $error("overflow trap current wrong");

   a_uf_trap_bit: assert property ( // RULE11
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && exc.ieee_trap && flags[EX_UF] && !flags[EX_OF] &&
       trap_enable_mask_field_q[EX_UF])
      |=> current_exception_field_q == 5'h04)
      else $error("underflow trap current wrong");

   a_of_no_trap: assert property ( // RULE10
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && exc.ttype == FPES_TT_NONE &&
       i_raw.ovf_rounded && i_raw.inexact)
      |=> (current_exception_field_q[EX_OF] &&
           current_exception_field_q[EX_NX]))
      else $error("untrapped overflow bits wrong");

   a_uf_zero: assert property ( // RULE17
      @(posedge i_clk) disable iff (i_rst)
      i_raw.result_zero_unrounded
      |-> !flags[EX_UF])
      else $error("underflow on zero result");

   a_trap_apart: assert property ( // RULE21
      @(posedge i_clk) disable iff (i_rst)
      o_float_ieee_trap
      |-> !o_float_misc_trap)
      else $error("both trap requests raised");

   a_idle_quiet: assert property ( // RULE9
      @(posedge i_clk) disable iff (i_rst)
      !i_op_done
      |=> !(o_float_ieee_trap || o_float_misc_trap))
      else $error("trap request without operation");

   a_nv_trap_bit: assert property ( // RULE23
      @(posedge i_clk) disable iff (i_rst)
      (i_op_done && exc.ieee_trap &&
       (flags & trap_enable_mask_field_q) == 5'h10)
      |=> current_exception_field_q == 5'h10)
      else $error("invalid trap current wrong");
endmodule

// file: test/fpes_trap_sink.sv
// Purpose: Trap logic stand-in that receives the unit's trap requests
// Assumes: Each trap request is a one-cycle pulse on the core clock
// Notes:   Counts taken trap requests for the bench to compare at the end
`timescale 1ns/1ps
module fpes_trap_sink (
   input  wire logic   i_clk,
   input  wire logic   i_rst,
   input  wire logic   i_ieee,
   input  wire logic   i_misc,
   output logic [15:0] o_n_ieee,
   output logic [15:0] o_n_misc
);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_n_ieee <= 16'h0000;
         o_n_misc <= 16'h0000;
      end else begin
         o_n_ieee <= o_n_ieee + {15'h0000, i_ieee};
         o_n_misc <= o_n_misc + {15'h0000, i_misc};
      end
   end
endmodule

// file: test/fp_exception_status_test.sv
// Purpose: Self-checking bench for the float exception status unit
// Assumes: Inputs change at the falling edge, results land at the next rising edge
// Notes:   Drivers queue expected status words, a watcher compares them
`timescale 1ns/1ps
module fp_exception_status_test;
   import fpes_pkg::*;
   typedef struct packed {
      logic [31:0] st;
      logic        ieee;
      logic        misc;
   } fpes_note_t;
   logic        i_clk;
   logic        i_rst;
   logic        op_done;
   fpes_raw_t   raw;
   logic        unsup;
   logic        quad;
   logic [4:0]  reg_a;
   logic [4:0]  reg_b;
   logic        incomp;
   logic        ld;
   logic        ldw;
   logic [31:0] ld_data;
   logic        st_done;
   logic [31:0] status;
   logic        ieee;
   logic        misc;
   logic [15:0] n_ieee;
   logic [15:0] n_misc;
   logic [4:0]  e_mask;
   logic [4:0]  e_acc;
   logic [4:0]  e_cur;
   logic [2:0]  e_tt;
   logic [31:0] seed;
   logic [1:0]  kv;
   fpes_note_t  notes[$];
   fpes_note_t  nt;
   int          n_errors;
   int          check_count;
   int          n_ieee_exp;
   int          n_misc_exp;
   int          cyc;

   fpes_top fpes_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_op_done(op_done),
      .i_raw(raw), .i_unsupported(unsup), .i_quad(quad), .i_reg_a(reg_a),
      .i_reg_b(reg_b), .i_reg_d(reg_a), .i_incomplete(incomp),
      .i_load_status(ld), .i_load_status_wide(ldw), .i_load_data(ld_data),
      .i_store_done(st_done), .o_fp_status_reg(status),
      .o_float_ieee_trap(ieee), .o_float_misc_trap(misc));
   fpes_trap_sink fpes_trap_sink_i (.i_clk(i_clk), .i_rst(i_rst),
      .i_ieee(ieee), .i_misc(misc), .o_n_ieee(n_ieee), .o_n_misc(n_misc));

   // ---------------------------------------------------------------
   // Reference model and checks
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] stat();
      stat = {4'h0, e_mask, 6'h00, e_tt, 4'h0, e_acc, e_cur};
   endfunction

   task automatic chk_w(input string nm, input logic [31:0] e,
                        input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chk_b(input string nm, input logic e, input logic s);
      chk_w(nm, {31'h0, e}, {31'h0, s});
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Drivers, each entered at a falling edge and left at the next
   // ---------------------------------------------------------------
   task automatic op(input logic [5:0] r, input logic us, input logic q,
                     input logic [4:0] ra, input logic inc);
      logic [4:0] f;
      logic [4:0] en;
      logic       uf;
      logic       tr;
      logic       mt;
      op_done = 1'b1;
      ld = 1'b0;
      ldw = 1'b0;
      st_done = 1'b0;
      raw = fpes_raw_t'(r);
      unsup = us;
      quad = q;
      reg_a = ra;
      // Second source takes its low bits from the top of the first
      reg_b = {ra[2:0], ra[4:3]};
      incomp = inc;
      uf = r[2] & ~r[1] & (e_mask[EX_UF] | r[0]);
      f = {r[5], r[3], uf, r[4], r[0]};
      en = f & e_mask;
      tr = 1'b0;
      mt = 1'b1;
      if (us) begin
         e_tt = 3'h3;
      end else if (q && (ra[1:0] != 2'h0 || ra[4:3] != 2'h0)) begin
         e_tt = 3'h6;
      end else if (inc) begin
         e_tt = 3'h2;
      end else begin
         mt = 1'b0;
         tr = (en != 5'h00);
         e_tt = {2'h0, tr};
         if (!tr) begin
            e_cur = f;
            e_acc = e_acc | f;
         end else if (en[EX_OF]) begin
            e_cur = 5'h08;
         end else if (en[EX_UF]) begin
            e_cur = 5'h04;
         end else if (en[EX_NV]) begin
            e_cur = 5'h10;
         end else if (en[EX_DZ]) begin
            e_cur = 5'h02;
         end else begin
            e_cur = 5'h01;
         end
      end
      n_ieee_exp += int'(tr);
      n_misc_exp += int'(mt);
      notes.push_back({stat(), tr, mt});
      @(negedge i_clk);
   endtask

   task automatic load(input logic [31:0] d, input logic wide);
      op_done = 1'b0;
      ld = ~wide;
      ldw = wide;
      st_done = 1'b0;
      ld_data = d;
      e_mask = d[27:23];
      e_acc = d[9:5];
      e_cur = d[4:0];
      notes.push_back({stat(), 1'b0, 1'b0});
      @(negedge i_clk);
   endtask

   task automatic store();
      op_done = 1'b0;
      ld = 1'b0;
      ldw = 1'b0;
      st_done = 1'b1;
      e_tt = 3'h0;
      notes.push_back({stat(), 1'b0, 1'b0});
      @(negedge i_clk);
   endtask

   // ---------------------------------------------------------------
   // Watcher and hang guard
   // ---------------------------------------------------------------
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 1000) begin
         n_errors++;
         conclude();
      end else if (!i_rst && (op_done || ld || ldw || st_done)) begin
         #1;
         nt = notes.pop_front();
         chk_w("status word", nt.st, status);
         chk_b("ieee trap", nt.ieee, ieee);
         chk_b("misc trap", nt.misc, misc);
      end else if (!i_rst) begin
         #1;
         chk_b("ieee trap idle", 1'b0, ieee);
         chk_b("misc trap idle", 1'b0, misc);
      end
   end

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      i_rst = 1'b1;
      {op_done, unsup, quad, incomp, ld, ldw, st_done} = 7'h00;
      raw = fpes_raw_t'(6'h00);
      reg_a = 5'h00;
      reg_b = 5'h00;
      ld_data = 32'h00000000;
      {e_mask, e_acc, e_cur, e_tt} = 18'h00000;
      seed = 32'hC799D48C;
      repeat (3) @(negedge i_clk);
      i_rst = 1'b0;
      chk_w("reset status", stat(), status);
      $display("test reset done");
      load(32'hFFFFFFFF, 1'b0);
      load(32'h00000000, 1'b1);
      $display("test load done");
      for (int k = 0; k < 4; k++) begin
         kv = 2'(k);
         load({5'h00, kv[1], kv[1], 1'b0, kv[0], 23'h000000}, kv[0]);
         op(6'h09, 1'b0, 1'b0, 5'h00, 1'b0);
         op(6'h05, 1'b0, 1'b0, 5'h00, 1'b0);
         op(6'h04, 1'b0, 1'b0, 5'h00, 1'b0);
         op(6'h06, 1'b0, 1'b0, 5'h00, 1'b0);
      end
      load({4'h0, 5'h12, 23'h000000}, 1'b0);
      op(6'h20, 1'b0, 1'b0, 5'h00, 1'b0);
      op(6'h10, 1'b0, 1'b0, 5'h00, 1'b0);
      op(6'h30, 1'b0, 1'b0, 5'h00, 1'b0);
      load(32'h00000000, 1'b0);
      op(6'h30, 1'b0, 1'b0, 5'h00, 1'b0);
      $display("test ieee traps done");
      op(6'h09, 1'b1, 1'b1, 5'h01, 1'b1);
      op(6'h21, 1'b0, 1'b1, 5'h02, 1'b1);
      op(6'h09, 1'b0, 1'b1, 5'h04, 1'b1);
      op(6'h09, 1'b0, 1'b1, 5'h03, 1'b0);
      load(32'h00000000, 1'b1);
      store();
      $display("test misc traps done");
      for (int k = 0; k < 60; k++) begin
         seed = lfsr(seed);
         if (seed[16]) begin
            load(lfsr(seed), seed[17]);
         end
         op(seed[5:0], seed[6] & seed[7], seed[8], seed[13:9],
            seed[14] & seed[15]);
      end
      $display("test random ops done");
      {op_done, ld, ldw, st_done} = 4'h0;
      repeat (2) @(negedge i_clk);
      chk_w("ieee trap count", 32'(n_ieee_exp), {16'h0000, n_ieee});
      chk_w("misc trap count", 32'(n_misc_exp), {16'h0000, n_misc});
      chk_w("notes left", 32'h00000000, 32'(notes.size()));
      $display("test trap counts done");
      conclude();
   end
endmodule
